// >>> shared/pso_pkg.sv
// Shared types and constants for the pipelined sample output port
package pso_pkg;

    // ----------------------------------------------------------------
    // Widths and depths
    // ----------------------------------------------------------------
    localparam int CODE_W      = 8;
    localparam int LEVEL_W     = 10;
    localparam int FIFO_DEPTH  = 16;
    localparam int SYNC_STAGES = 3;

    // ----------------------------------------------------------------
    // Code values and reset values
    // ----------------------------------------------------------------
    localparam logic [CODE_W-1:0]  CODE_ALL_ZEROS = 8'h00;
    localparam logic [CODE_W-1:0]  CODE_ALL_ONES  = 8'hFF;
    localparam logic [CODE_W-1:0]  CODE_RESET     = 8'h00;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET    = 10'h000;
    localparam logic               CONV_CLK_RESET = 1'b0;
    localparam logic               OE_B_RESET     = 1'b1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int MCLK_PERIOD_NS  = 40;
    localparam int MAX_RATE_MSPS   = 30;
    // Half-cycle count of the conversion clock: fall to third rise
    localparam int LATENCY_HALVES  = 5;
    localparam int LATENCY_RISES   = (LATENCY_HALVES + 1) / 2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [LEVEL_W-1:0] sample;
        logic [LEVEL_W-1:0] top;
        logic [LEVEL_W-1:0] bottom;
    } pso_levels_t;

    typedef struct packed {
        logic              valid;
        logic [CODE_W-1:0] code;
    } pso_code_t;

endpackage

// >>> src/pso_fifo.sv
// Parameterised valid/ready FIFO for conversion codes
`timescale 1ns/1ps
module pso_fifo
    import pso_pkg::*;
#(
    parameter int WIDTH = CODE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } pso_fifo_state_t;

    pso_fifo_state_t st_reg;
    pso_fifo_state_t st_next;

    logic push;
    logic pop;

    always_comb begin
        in_ready  = (st_reg.count != (AW+1)'(DEPTH));
        out_valid = (st_reg.count != '0);
        out_data  = st_reg.mem[st_reg.rd_ptr];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        st_next   = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = in_data;
            st_next.wr_ptr             = st_reg.wr_ptr + AW'(1);
        end
        if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + (AW+1)'(1);
        end else if (pop && !push) begin
            st_next.count = st_reg.count - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// >>> src/pso_top.sv
// Digital side of an 8-bit pipelined sampling converter
// Contract
// - Sample on each conversion-clock fall and present its code 2.5 cycles later.
// - Every result is an 8-bit word, at conversion rates up to a quarter of MCLK (6.25 MSPS), short of the 30 MSPS top rate.
// - Inputs below the bottom level give all zeros, above the top level all ones.
// - Conversion runs for as long as conversion-clock edges arrive, with no start command.
// - Output enable low drives the code pins, high releases them.
// - A fresh code appears each cycle, lagging its own sample by the fixed latency.
// - Codes change only after a conversion-clock rise; the old code holds until then.
`timescale 1ns/1ps
module pso_top
    import pso_pkg::*;
(
    // System clock and reset
    input  wire logic               MCLK,
    input  wire logic               RST_B,
    // Conversion clock from the capture side
    input  wire logic               CONV_CLK,
    // Quantised front-end levels
    input  wire logic [LEVEL_W-1:0] ANALOG_SAMPLE_INPUT,
    input  wire logic [LEVEL_W-1:0] TOP_REFERENCE_LEVEL,
    input  wire logic [LEVEL_W-1:0] BOTTOM_REFERENCE_LEVEL,
    // Output enable, active low
    input  wire logic               OUTPUT_ENABLE_B,
    // Code pins, three signals per two-state-plus-release pin group
    output logic [CODE_W-1:0]       CODE_OUT,
    output logic [CODE_W-1:0]       CODE_OE,
    output logic                    CODE_IN_UNUSED_B
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_STAGES-1:0]              clk_sync;
        logic [SYNC_STAGES-1:0]              oe_b_sync;
        logic [SYNC_STAGES-1:0][LEVEL_W-1:0] smp_sync;
        logic [SYNC_STAGES-1:0][LEVEL_W-1:0] top_sync;
        logic [SYNC_STAGES-1:0][LEVEL_W-1:0] bot_sync;
        logic                                clk_level;
        logic                                oe_b_level;
        pso_code_t                           stage_a;
        pso_code_t                           stage_b;
        logic [CODE_W-1:0]                   code_out;
        logic [CODE_W-1:0]                   code_oe;
    } pso_state_t;

    pso_state_t st_reg;
    pso_state_t st_next;

    // ----------------------------------------------------------------
    // Quantiser
    // ----------------------------------------------------------------
    // Scales the sample into the reference span; clips outside it
    function automatic logic [CODE_W-1:0] quantise(input pso_levels_t lv);
        logic [LEVEL_W-1:0]          span;
        logic [LEVEL_W-1:0]          offs;
        logic [LEVEL_W+CODE_W-1:0]   prod;
        logic [LEVEL_W+CODE_W-1:0]   quot;
        span = lv.top - lv.bottom;
        offs = lv.sample - lv.bottom;
        prod = (LEVEL_W+CODE_W)'(offs) * (LEVEL_W+CODE_W)'(CODE_ALL_ONES);
        quot = '0;
        if (lv.sample < lv.bottom) begin
            quantise = CODE_ALL_ZEROS;
        end else if (lv.sample >= lv.top) begin
            quantise = CODE_ALL_ONES;
        end else begin
            // Span is non-zero here since bottom <= sample < top
            quot     = prod / (LEVEL_W+CODE_W)'(span);
            quantise = quot[CODE_W-1:0];
        end
    endfunction

    // ----------------------------------------------------------------
    // Edge detection and sampling
    // ----------------------------------------------------------------
    logic          clk_agree;
    logic          conv_fall;
    logic          conv_rise;
    logic          oe_agree;
    pso_levels_t   levels;
    logic [CODE_W-1:0] sample_code;

    // Fifo handshake
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [CODE_W-1:0] fifo_out_data;
    logic              push_valid;
    logic              pop_ready;

    always_comb begin
        clk_agree   = (st_reg.clk_sync[1] == st_reg.clk_sync[2]);
        oe_agree    = (st_reg.oe_b_sync[1] == st_reg.oe_b_sync[2]);
        // Edge only once stages two and three agree, which filters glitches
        conv_fall   = clk_agree && st_reg.clk_level && !st_reg.clk_sync[2];
        conv_rise   = clk_agree && !st_reg.clk_level && st_reg.clk_sync[2];
        levels.sample = st_reg.smp_sync[2];
        levels.top    = st_reg.top_sync[2];
        levels.bottom = st_reg.bot_sync[2];
        sample_code   = quantise(levels);
        // Each fall takes a sample with no start command
        push_valid    = conv_fall;
        pop_ready     = conv_rise;
    end

    // Codes wait here from the fall until the next rise moves them on
    pso_fifo #(
        .WIDTH (CODE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .rst_b     (RST_B),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (sample_code),
        .out_valid (fifo_out_valid),
        .out_ready (pop_ready),
        .out_data  (fifo_out_data)
    );

    // ----------------------------------------------------------------
    // Pipeline and output stage
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // Three-stage synchronisers; stage one feeds stage two only
        st_next.clk_sync  = {st_reg.clk_sync[1:0], CONV_CLK};
        st_next.oe_b_sync = {st_reg.oe_b_sync[1:0], OUTPUT_ENABLE_B};
        st_next.smp_sync  = {st_reg.smp_sync[1:0], ANALOG_SAMPLE_INPUT};
        st_next.top_sync  = {st_reg.top_sync[1:0], TOP_REFERENCE_LEVEL};
        st_next.bot_sync  = {st_reg.bot_sync[1:0], BOTTOM_REFERENCE_LEVEL};

        if (clk_agree) begin
            st_next.clk_level = st_reg.clk_sync[2];
        end
        if (oe_agree) begin
            st_next.oe_b_level = st_reg.oe_b_sync[2];
        end

        // A sample is lost only if the fifo is full, which cannot last
        // because every rise drains one entry
        if (push_valid && !fifo_in_ready) begin
            st_next.stage_a.valid = 1'b0;
        end

        // Rise one takes the code, rise two moves it, rise three shows it
        if (conv_rise) begin
            if (fifo_out_valid) begin
                st_next.stage_a.valid = 1'b1;
                st_next.stage_a.code  = fifo_out_data;
            end
            st_next.stage_b  = st_reg.stage_a;
            if (st_reg.stage_b.valid) begin
                st_next.code_out = st_reg.stage_b.code;
            end
        end

        // Pin release follows the filtered enable level
        st_next.code_oe = {CODE_W{!st_next.oe_b_level}};
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg.clk_sync   <= {SYNC_STAGES{CONV_CLK_RESET}};
            st_reg.oe_b_sync  <= {SYNC_STAGES{OE_B_RESET}};
            st_reg.smp_sync   <= {SYNC_STAGES{LEVEL_RESET}};
            st_reg.top_sync   <= {SYNC_STAGES{LEVEL_RESET}};
            st_reg.bot_sync   <= {SYNC_STAGES{LEVEL_RESET}};
            st_reg.clk_level  <= CONV_CLK_RESET;
            st_reg.oe_b_level <= OE_B_RESET;
            st_reg.stage_a    <= '0;
            st_reg.stage_b    <= '0;
            st_reg.code_out   <= CODE_RESET;
            st_reg.code_oe    <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Pins are output only; the input leg is flagged unused only while the pins are driven
    always_comb begin
        CODE_OUT         = st_reg.code_out;
        CODE_OE          = st_reg.code_oe;
        CODE_IN_UNUSED_B = st_reg.oe_b_level;
    end

endmodule

// >>> tb/pso_top_asserts.sv
// Checker for the code port of the converter
`timescale 1ns/1ps
module pso_top_asserts
    import pso_pkg::*;
(
    // Clock and reset
    input wire logic              MCLK,
    input wire logic              RST_B,
    // Watched pins
    input wire logic              CONV_CLK,
    input wire logic              OUTPUT_ENABLE_B,
    input wire logic [CODE_W-1:0] CODE_OUT,
    input wire logic [CODE_W-1:0] CODE_OE,
    input wire logic              CODE_IN_UNUSED_B
);
    default clocking dc @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    // ----------------------------------------------------------------
    // Edges since last clock rise
    // ----------------------------------------------------------------
    logic [3:0] rise_age_reg;
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rise_age_reg <= 4'hF;
        end else if ($rose(CONV_CLK)) begin
            rise_age_reg <= 4'h0;
        end else if (rise_age_reg != 4'hF) begin
            rise_age_reg <= rise_age_reg + 4'h1;
        end
    end

    a_oe_all_bits: assert property (CODE_OE == 8'h00 || CODE_OE == 8'hFF)
        else $error("code pin enables disagree");
    a_oe_flag_match: assert property (
        CODE_IN_UNUSED_B == (CODE_OE == 8'h00))
        else $error("release flag and enables differ");
    a_enable_on: assert property (
        $fell(OUTPUT_ENABLE_B) ##1 !OUTPUT_ENABLE_B [*5] |-> CODE_OE == 8'hFF)
        else $error("pins not driven after enable");
    a_enable_off: assert property (
        $rose(OUTPUT_ENABLE_B) ##1 OUTPUT_ENABLE_B [*5] |-> CODE_OE == 8'h00)
        else $error("pins not released after disable");
    a_enable_cause: assert property (
        $changed(CODE_OE) |-> $past(OUTPUT_ENABLE_B, 3) == (CODE_OE == 8'h00))
        else $error("pin enables moved without cause");
    a_code_timing: assert property (
        $changed(CODE_OUT) && $past(RST_B) |-> rise_age_reg inside {[4'h2:4'h6]})
        else $error("code changed away from a clock rise");
    a_one_per_rise: assert property (
        $changed(CODE_OUT) |=> $stable(CODE_OUT) [*4])
        else $error("code changed twice in one cycle");
    a_halt_freeze: assert property (
        $stable(CONV_CLK) [*8] |=> $stable(CODE_OUT))
        else $error("code moved with the clock halted");
    a_reset_values: assert property (
        $rose(RST_B) |-> CODE_OUT == CODE_RESET && CODE_OE == 8'h00 && CODE_IN_UNUSED_B)
        else $error("outputs wrong during reset");

    c_code_change: cover property ($changed(CODE_OUT));
    c_halted: cover property ($stable(CONV_CLK) [*8]);
    c_released: cover property ($rose(CODE_IN_UNUSED_B));
endmodule

// >>> tb/pso_capture_model.sv
// Capture-side model: conversion clock source and code latch
`timescale 1ns/1ps
module pso_capture_model
    import pso_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // Bench control
    input  wire logic              run,
    input  wire logic [3:0]        half,
    input  wire pso_levels_t       lv,
    // Device side
    output logic                   conv_clk,
    input  wire logic [CODE_W-1:0] pins,
    // Results
    output logic                   rose,
    output logic                   cap_stb,
    output logic [CODE_W-1:0]      cap_code,
    output pso_levels_t            cap_lv
);
    pso_levels_t q[$];
    logic [3:0]  cnt;
    logic [2:0]  wait_cnt;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            conv_clk <= 1'b0;
            rose     <= 1'b0;
            cap_stb  <= 1'b0;
            cnt      <= 4'h0;
            wait_cnt <= 3'h0;
            q.delete();
        end else begin
            rose    <= 1'b0;
            cap_stb <= 1'b0;
            // Latch once the output delay is over, tag three falls back
            if (wait_cnt == 3'h6) begin
                wait_cnt <= 3'h0;
                if (q.size() >= 3) begin
                    cap_stb  <= 1'b1;
                    cap_code <= pins;
                    cap_lv   <= q.pop_front();
                end
            end else if (wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt + 3'h1;
            end
            // Halt only in the low phase; a high halt wastes power
            if (run || conv_clk) begin
                cnt <= cnt + 4'h1;
                if (cnt + 4'h1 >= half) begin
                    cnt      <= 4'h0;
                    conv_clk <= !conv_clk;
                    if (conv_clk) begin
                        q.push_back(lv);
                    end else begin
                        rose     <= 1'b1;
                        wait_cnt <= 3'h1;
                    end
                end
            end
        end
    end
endmodule

// >>> tb/tb_pipelined_sample_output_port.sv
// Self-checking bench for the pipelined sample output port
`timescale 1ns/1ps
module tb_pipelined_sample_output_port
    import pso_pkg::*;
;
    logic              mclk, rst_b, conv_clk, oe_b, run, rose, stb, unused_b;
    logic [3:0]        half;
    logic [CODE_W-1:0] code_out, code_oe, pins, cap_code;
    pso_levels_t       lv, cap_lv;
    logic [9:0]        tbl [8];
    int                failures, compares, caps;

    pso_top dut (.MCLK(mclk), .RST_B(rst_b), .CONV_CLK(conv_clk),
        .ANALOG_SAMPLE_INPUT(lv.sample), .TOP_REFERENCE_LEVEL(lv.top),
        .BOTTOM_REFERENCE_LEVEL(lv.bottom), .OUTPUT_ENABLE_B(oe_b),
        .CODE_OUT(code_out), .CODE_OE(code_oe), .CODE_IN_UNUSED_B(unused_b));
    pso_capture_model u_cap (.mclk(mclk), .rst_b(rst_b), .run(run), .half(half),
        .lv(lv), .conv_clk(conv_clk), .pins(pins), .rose(rose), .cap_stb(stb),
        .cap_code(cap_code), .cap_lv(cap_lv));
    // Released bus reads back as the inverse of the last code
    assign pins = (code_oe == 8'hFF) ? code_out : ~code_out;

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] expect_code(pso_levels_t l);
        if (l.sample < l.bottom) return CODE_ALL_ZEROS;
        if (l.sample >= l.top) return CODE_ALL_ONES;
        return 8'(((l.sample - l.bottom) * 32'd255) / (l.top - l.bottom));
    endfunction

    always @(posedge mclk) begin
        if (stb === 1'b1) begin
            caps++;
            check8(cap_code, expect_code(cap_lv));
        end
    end

    task automatic wait_rose();
        int k;
        for (k = 0; k < 64; k++) begin
            @(posedge mclk);
            if (rose === 1'b1) break;
        end
        if (k == 64) begin
            failures++;
            give_verdict();
        end
    endtask

    // New level after each rise, so it is stable through the fall
    task automatic stream(input logic [3:0] h, input logic [9:0] t, input logic [9:0] b);
        int n0;
        n0 = caps;
        half <= h;
        lv.top <= t;
        lv.bottom <= b;
        run <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            wait_rose();
            lv.sample <= tbl[i % 8];
        end
        check8(8'(caps - n0 >= 6), 8'h01);
    endtask

    task automatic s_clip();
        tbl = '{10'h000, 10'h0C7, 10'h0C8, 10'h0C9, 10'h1F4, 10'h31F, 10'h320, 10'h3FF};
        stream(4'h8, 10'h320, 10'h0C8);
    endtask

    task automatic s_fast();
        tbl = '{10'h000, 10'h001, 10'h004, 10'h100, 10'h200, 10'h2FF, 10'h3FE, 10'h3FF};
        stream(4'h3, 10'h3FF, 10'h000);
    endtask

    task automatic s_halt();
        run <= 1'b0;
        repeat (40) @(posedge mclk);
        check8({7'h0, conv_clk}, 8'h00);
    endtask

    task automatic s_enable();
        oe_b <= 1'b1;
        repeat (8) @(posedge mclk);
        check8(code_oe, 8'h00);
        check8({7'h0, unused_b}, 8'h01);
        oe_b <= 1'b0;
        repeat (8) @(posedge mclk);
        check8(code_oe, 8'hFF);
    endtask

    task automatic s_reset();
        wait_rose();
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        check8(code_out, CODE_RESET);
        check8(code_oe, 8'h00);
        rst_b <= 1'b1;
        wait_rose();
        wait_rose();
        repeat (6) @(posedge mclk);
        check8(code_out, CODE_RESET);
        repeat (40) @(posedge mclk);
    endtask

    initial begin
        rst_b = 1'b0;
        oe_b = 1'b0;
        run = 1'b0;
        half = 4'h8;
        lv = '0;
        failures = 0;
        compares = 0;
        caps = 0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        s_clip();
        s_fast();
        s_halt();
        s_enable();
        s_clip();
        s_reset();
        give_verdict();
    end
endmodule

bind pso_top pso_top_asserts u_chk (.MCLK(MCLK), .RST_B(RST_B), .CONV_CLK(CONV_CLK),
    .OUTPUT_ENABLE_B(OUTPUT_ENABLE_B), .CODE_OUT(CODE_OUT), .CODE_OE(CODE_OE),
    .CODE_IN_UNUSED_B(CODE_IN_UNUSED_B));
